// >>> inc/mapc_params.svh
// constants for the multifunction alert pin configuration block
// How it works
// R1: two low config bits pick function: comms/unused, output, alert, analog.
// R2: in alert mode option bit 7 sets polarity; output mode ignores it.
// R3: option bit 3 clear makes a commanded high tri-state; set drives high.
// R4: option bit 5 set forces active high drive, overriding the tri-state choice.
// R5: option bit 5 picks high rail: 0 is 1.8 V rail, 1 the other.
// R6: option bit 4 enables weak pull-up to rail; software avoids it with bit 5.
// R7: option bit 2 enables the weak pull-down to ground in output modes.
// R8: analog bits 7:6 pick pull-up: 18k, 180k, none.
// R9: analog bits 5:4 pick conversion: 18K, 180K, custom, raw counts.
// R10: analog bits 3:2 pick measurement: analog, cell, report-only, switch thermistor.
// R11: option bits are reinterpreted by the selected pin function.
// R12: bit 6 ignored in output modes; pull-up code 11 means no pull-up.
`ifndef MAPC_PARAMS_SVH
`define MAPC_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define MAPC_ADDR_CFG     12'h000
`define MAPC_ADDR_STATUS  12'h004
`define MAPC_CFG_RESET    8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define MAPC_FXN_LO       0
`define MAPC_FXN_HI       1
`define MAPC_OPT_POL      7
`define MAPC_OPT_RAIL     5
`define MAPC_OPT_PU       4
`define MAPC_OPT_DRVHI    3
`define MAPC_OPT_PD       2
`define MAPC_AN_PU_HI     7
`define MAPC_AN_PU_LO     6
`define MAPC_AN_POLY_HI   5
`define MAPC_AN_POLY_LO   4
`define MAPC_AN_MEAS_HI   3
`define MAPC_AN_MEAS_LO   2
`endif

// >>> inc/mapc_pkg.sv
// types for the multifunction alert pin configuration block
package mapc_pkg;
    typedef enum logic [1:0] {MAPC_FXN_COMMS, MAPC_FXN_GPO, MAPC_FXN_ALERT, MAPC_FXN_ANALOG} mapc_fxn_e;
    typedef enum logic [1:0] {MAPC_PU_18K, MAPC_PU_180K, MAPC_PU_NONE} mapc_pu_e;
    typedef struct packed {
        logic [7:0] cfg;
        logic [2:0] cmd_sync;
        logic       cmd;
        logic [1:0] pad;     // {drive out, output enable}
        logic [2:0] pulls;   // {pull-up, pull-down, rail select}
        logic [1:0] an_pu;
        logic [1:0] an_poly;
        logic [1:0] an_meas;
        logic       an_en;
        logic [1:0] fxn;
        logic       pready;
        logic [31:0] prdata;
        logic       pslverr;
    } mapc_state_s;
endpackage : mapc_pkg

// >>> verilog/mapc_pin_config.sv
// decoder for the multifunction alert pin configuration byte with APB access
`timescale 1ns/1ps
`include "mapc_params.svh"
module mapc_pin_config
    import mapc_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // pin commands from the rest of the device
    input  wire logic        gpo_level,
    input  wire logic        alert_event,
    // pad control
    output logic             pad_out,
    output logic             pad_oe,
    output logic             pad_pullup_en,
    output logic             pad_pulldown_en,
    output logic             pad_rail_first_ldo,
    // analog front end control
    output logic             analog_input_mode,
    output logic [1:0]       analog_pullup_sel,
    output logic [1:0]       analog_poly_sel,
    output logic [1:0]       analog_meas_type,
    output logic [1:0]       pin_function_select
);
    mapc_state_s q, d;
    logic [7:0]  c;
    logic        hi;
    logic        is_out;
    logic        wr_acc;
    logic        rd_acc;
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == `MAPC_ADDR_CFG) || (a == `MAPC_ADDR_STATUS);
    endfunction : addr_known
    // output modes share the pad driver; used by the decode and by the checks
    function automatic logic out_mode(input logic [1:0] f);
        out_mode = (f == MAPC_FXN_GPO) || (f == MAPC_FXN_ALERT);
    endfunction : out_mode

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        c = q.cfg;
        wr_acc = psel && penable && pwrite && !q.pready;
        rd_acc = psel && penable && !pwrite && !q.pready;
        // single-cycle wait state: pready rises in the access cycle's first edge
        d.pready = psel && penable && !q.pready;
        d.pslverr = (psel && penable && !q.pready) ? !addr_known(paddr) : 1'b0;
        if (wr_acc && paddr == `MAPC_ADDR_CFG) begin
            d.cfg = pwdata[7:0];
        end
        if (rd_acc) begin
            if (paddr == `MAPC_ADDR_CFG) begin
                d.prdata = {24'h000000, q.cfg};
            end else if (paddr == `MAPC_ADDR_STATUS) begin
                d.prdata = {27'h0000000, q.pad, q.an_en, q.fxn};
            end else begin
                d.prdata = 32'h00000000;
            end
        end
        // gpo level comes from a pin domain: three flops, change when last two agree
        d.cmd_sync = {q.cmd_sync[1:0], gpo_level};
        d.fxn = c[`MAPC_FXN_HI:`MAPC_FXN_LO]; // R1
        is_out = out_mode(d.fxn);
        // commanded level: alert polarity only applies in alert mode
        if (d.fxn == MAPC_FXN_ALERT) begin
            hi = alert_event ^ c[`MAPC_OPT_POL]; // R2
        end else if (q.cmd_sync[2] == q.cmd_sync[1]) begin
            hi = q.cmd_sync[2]; // R2
        end else begin
            hi = q.cmd;
        end
        d.cmd = hi;
        // bit 6 has no role in output modes
        if (is_out) begin // R11 R12
            d.pad[1] = hi;
            // active drive when bit 3 set or high rail forced by bit 5
            d.pad[0] = !hi || c[`MAPC_OPT_DRVHI] || c[`MAPC_OPT_RAIL]; // R3 R4
            d.pulls = {c[`MAPC_OPT_PU], c[`MAPC_OPT_PD], c[`MAPC_OPT_RAIL]}; // R5 R6 R7
        end else begin
            d.pad = 2'b00;
            d.pulls = 3'b000;
        end
        d.an_en = (d.fxn == MAPC_FXN_ANALOG); // R11
        if (d.an_en) begin
            d.an_pu = c[`MAPC_AN_PU_HI:`MAPC_AN_PU_LO]; // R8
            if (d.an_pu == 2'b11) begin
                d.an_pu = MAPC_PU_NONE; // R12
            end
            d.an_poly = c[`MAPC_AN_POLY_HI:`MAPC_AN_POLY_LO]; // R9
            d.an_meas = c[`MAPC_AN_MEAS_HI:`MAPC_AN_MEAS_LO]; // R10
        end else begin
            d.an_pu = MAPC_PU_NONE;
            d.an_poly = 2'b00;
            d.an_meas = 2'b00;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.cfg <= `MAPC_CFG_RESET;
            q.an_pu <= MAPC_PU_NONE;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign pad_out = q.pad[1];
    assign pad_oe = q.pad[0];
    assign pad_pullup_en = q.pulls[2];
    assign pad_pulldown_en = q.pulls[1];
    assign pad_rail_first_ldo = q.pulls[0];
    assign analog_input_mode = q.an_en;
    assign analog_pullup_sel = q.an_pu;
    assign analog_poly_sel = q.an_poly;
    assign analog_meas_type = q.an_meas;
    assign pin_function_select = q.fxn;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // outputs are registered one edge after the byte and the commands that set
    // them, so most checks compare against the sampled values of the edge before

    // ----------------------------------------
    // function decode
    // ----------------------------------------
    // function select is the low pair of the stored byte
    fxn_decode_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        pin_function_select == $past(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO]))
        else $error("function select mismatch");

    // the analog flag belongs to the analog function alone
    analog_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        analog_input_mode == ($past(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO]) == MAPC_FXN_ANALOG))
        else $error("analog flag mismatch");

    // unused function leaves the pad free for the comms logic elsewhere
    pull_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (pin_function_select == MAPC_FXN_COMMS) |-> !pad_pullup_en && !pad_pulldown_en && !pad_oe)
        else $error("pulls active when unused");

    // ----------------------------------------
    // commanded level
    // ----------------------------------------
    // alert level follows the alert command through the polarity bit
    alert_pol_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
        ($past(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO]) == MAPC_FXN_ALERT)
        |-> pad_out == ($past(alert_event) ^ $past(q.cfg[`MAPC_OPT_POL])))
        else $error("alert polarity wrong");

    // output mode takes the settled level and never the polarity bit;
    // a change still in flight holds the previous level for a cycle
    gpo_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
        ($past(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO]) == MAPC_FXN_GPO && $past(q.cmd_sync[2] == q.cmd_sync[1]))
        |-> pad_out == $past(q.cmd_sync[2]))
        else $error("output level wrong");

    // ----------------------------------------
    // pad drive
    // ----------------------------------------
    // a commanded low is always driven
    low_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (out_mode(pin_function_select) && !pad_out) |-> pad_oe)
        else $error("low not driven");

    // drive-high option keeps the driver on for a high
    drive_high_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
        ($past(out_mode(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO])) && $past(q.cfg[`MAPC_OPT_DRVHI])) |-> pad_oe)
        else $error("high drive missing");

    // a floating high is only legal with both drive bits clear;
    // the upper rail cannot float because its pull-up is not guaranteed
    tristate_high_a: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
        (out_mode(pin_function_select) && pad_out && !pad_oe)
        |-> !$past(q.cfg[`MAPC_OPT_DRVHI]) && !$past(q.cfg[`MAPC_OPT_RAIL]))
        else $error("tri-state high not allowed");

    // upper rail forces active drive
    rail_force_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
        ($past(out_mode(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO])) && $past(q.cfg[`MAPC_OPT_RAIL])) |-> pad_oe)
        else $error("rail force lost");

    // ----------------------------------------
    // rail and weak pulls
    // ----------------------------------------
    // rail select mirrors its bit in output modes only
    rail_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        pad_rail_first_ldo == ($past(out_mode(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO])) && $past(q.cfg[`MAPC_OPT_RAIL])))
        else $error("rail select wrong");

    // pull-up mirrors its bit; software keeps it off with the upper rail,
    // the hardware obeys the byte either way
    pullup_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
        pad_pullup_en == ($past(out_mode(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO])) && $past(q.cfg[`MAPC_OPT_PU])))
        else $error("pull-up wrong");

    // pull-down mirrors its bit in output modes
    pulldown_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
        pad_pulldown_en == ($past(out_mode(q.cfg[`MAPC_FXN_HI:`MAPC_FXN_LO])) && $past(q.cfg[`MAPC_OPT_PD])))
        else $error("pull-down wrong");

    // ----------------------------------------
    // analog front end
    // ----------------------------------------
    // pull-up choice passes through unless it is the reserved code
    analog_pu_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
        (analog_input_mode && $past(q.cfg[`MAPC_AN_PU_HI:`MAPC_AN_PU_LO]) != 2'h3)
        |-> analog_pullup_sel == $past(q.cfg[`MAPC_AN_PU_HI:`MAPC_AN_PU_LO]))
        else $error("analog pull-up wrong");

    // reserved pull-up code never reaches the front end
    pu_code_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        analog_pullup_sel != 2'h3)
        else $error("reserved pull-up code");

    // conversion and measurement fields pass straight through
    analog_map_a: assert property (@(posedge pclk) disable iff (!presetn) // R9 R10
        analog_input_mode |-> analog_poly_sel == $past(q.cfg[`MAPC_AN_POLY_HI:`MAPC_AN_POLY_LO])
        && analog_meas_type == $past(q.cfg[`MAPC_AN_MEAS_HI:`MAPC_AN_MEAS_LO]))
        else $error("analog fields wrong");

    // outside analog mode the same bits must not steer the front end
    analog_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        !analog_input_mode |-> analog_pullup_sel == MAPC_PU_NONE
        && analog_poly_sel == 2'h0 && analog_meas_type == 2'h0)
        else $error("analog fields leak");

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    // exactly one wait state
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("apb late");

    // ready stands for one cycle only
    apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("apb ready stuck");

    // error only travels with ready
    apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("apb error without ready");

    // unmapped addresses answer with an error
    err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(psel && penable && !pready)
        |-> pslverr == $past(!addr_known(paddr)))
        else $error("apb error decode wrong");

    // a config write lands on the access edge
    cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(psel && penable && pwrite && !pready && paddr == `MAPC_ADDR_CFG)
        |-> q.cfg == $past(pwdata[7:0]))
        else $error("config write lost");

    // nothing else touches the stored byte
    cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(psel && penable && pwrite && !pready && paddr == `MAPC_ADDR_CFG)
        |-> q.cfg == $past(q.cfg))
        else $error("config changed without write");

    // config read returns the stored byte, upper bits zero
    cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(psel && penable && !pwrite && !pready && paddr == `MAPC_ADDR_CFG)
        |-> prdata == {24'h000000, $past(q.cfg)})
        else $error("config read wrong");

    // status read returns the pad and function state
    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(psel && penable && !pwrite && !pready && paddr == `MAPC_ADDR_STATUS)
        |-> prdata == {27'h0000000, $past(q.pad), $past(q.an_en), $past(q.fxn)})
        else $error("status read wrong");

    // ----------------------------------------
    // coverage
    // ----------------------------------------
    // main modes, a bus error and a pulled-up floating pin seen in use
    cov_alert_c: cover property (@(posedge pclk) pin_function_select == 2'h2 && pad_out);
    cov_gpo_c: cover property (@(posedge pclk) pin_function_select == 2'h1 && pad_out && !pad_oe);
    cov_analog_c: cover property (@(posedge pclk) analog_input_mode && analog_meas_type == 2'h3);
    cov_err_c: cover property (@(posedge pclk) pslverr);
    cov_pullup_c: cover property (@(posedge pclk) pad_pullup_en && pad_out && !pad_oe);
endmodule : mapc_pin_config

// >>> test/mapc_pin_watch.sv
// far-side watcher that resolves the level seen on the alert pin
`timescale 1ns/1ps
module mapc_pin_watch (
    // pad control from the block
    input  wire logic pad_out,
    input  wire logic pad_oe,
    input  wire logic pad_pullup_en,
    input  wire logic pad_pulldown_en,
    // resolved level outside
    output logic      pin_level
);
    logic drv_q = 1'b0;
    // remember the last driven level so a floating pin never echoes it
    always @(pad_out or pad_oe) if (pad_oe) drv_q = pad_out;
    // driver wins, then the weak pulls, else a floating pin flips
    always_comb begin
        if (pad_oe) pin_level = pad_out;
        else if (pad_pullup_en) pin_level = 1'b1;
        else if (pad_pulldown_en) pin_level = 1'b0;
        else pin_level = ~drv_q;
    end
endmodule : mapc_pin_watch

// >>> test/testbench.sv
// self-checking bench for the alert pin configuration block
`timescale 1ns/1ps
`include "mapc_params.svh"
module testbench;
    import mapc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic gpo_level = 1'b0, alert_event = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pad_out, pad_oe, pu_en, pd_en, rail, an_mode, pin_level;
    logic [1:0] an_pu, an_poly, an_meas, fxn;
    logic [32:0] exp_q[$];
    logic [13:0] e;
    logic [7:0] lfsr_q = 8'h4A;
    logic [7:0] cfg;
    int num_errors = 0, tests_run = 0;

    mapc_pin_config mapc_pin_config_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .gpo_level(gpo_level), .alert_event(alert_event), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pu_en), .pad_pulldown_en(pd_en), .pad_rail_first_ldo(rail),
        .analog_input_mode(an_mode), .analog_pullup_sel(an_pu), .analog_poly_sel(an_poly),
        .analog_meas_type(an_meas), .pin_function_select(fxn));
    mapc_pin_watch mapc_pin_watch_i (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pu_en),
        .pad_pulldown_en(pd_en), .pin_level(pin_level));

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    // expected {out, oe, pull-up, pull-down, rail, analog, pull sel, poly, meas, function}
    function automatic logic [13:0] pins(input logic [7:0] c, input logic g, input logic a);
        logic om, hi, an;
        om = (c[1:0] == 2'd1) || (c[1:0] == 2'd2);
        hi = (c[1:0] == 2'd1) ? g : (a ^ c[7]);
        an = (c[1:0] == 2'd3);
        return {om & hi, om & (~hi | c[3] | c[5]), om & c[4], om & c[2], om & c[5], an,
                an ? ((c[7:6] == 2'd3) ? 2'd2 : c[7:6]) : 2'd2, an ? c[5:4] : 2'd0, an ? c[3:2] : 2'd0, c[1:0]};
    endfunction : pins

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) exp_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // read results are matched against the oldest note
    always @(posedge pclk) if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
        check({pslverr, prdata}, exp_q.pop_front(), "read");
    end

    initial forever #20 pclk = ~pclk;

    // watchdog far beyond the roughly 740 cycles the sequence needs
    initial begin
        #(40 * 20000);
        num_errors++;
        give_verdict;
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MAPC_ADDR_CFG, 32'h0, {25'h0, `MAPC_CFG_RESET});
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
        // every function in turn, options and commands random
        for (int i = 0; i < 40; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            cfg = {lfsr_q[7:2], i[1:0]};
            if (cfg[5]) cfg[4] = 1'b0;
            apb(1'b1, `MAPC_ADDR_CFG, {lfsr_q, lfsr_q, lfsr_q, cfg}, 33'h0);
            gpo_level <= lfsr_q[0];
            alert_event <= lfsr_q[1];
            // gpo level crosses a three-flop synchroniser
            repeat (6) @(posedge pclk);
            e = pins(cfg, lfsr_q[0], lfsr_q[1]);
            check({pad_out, pad_oe, pu_en, pd_en, rail, an_mode, an_pu, an_poly, an_meas, fxn}, e, "pins");
            if (e[12]) check(pin_level, e[13], "pin");
            else if (e[11]) check(pin_level, 1'b1, "pull-up");
            else if (e[10]) check(pin_level, 1'b0, "pull-down");
            apb(1'b0, `MAPC_ADDR_CFG, 32'h0, {25'h0, cfg});
            apb(1'b0, `MAPC_ADDR_STATUS, 32'h0, {28'h0, e[13:12], e[8], e[1:0]});
        end
        give_verdict;
    end
endmodule : testbench
